// File: include/spt_pkg.sv
// Package holding the constants and the phase lookup function of the stepper translator and chopper.
// Summary of operation
// - Advance once per step clock rising edge.
// - Reset returns to state 1, phases 0101.
// - Anticlockwise walks the sequence in reverse.
// - Half mode high visits all eight states.
// - Half step alternates one and two phases.
// - Full mode at odd state: two-phase drive.
// - Two-phase drive keeps both inhibits high.
// - Full mode at even state: wave drive.
// - Half and wave pull idle pair inhibit low.
// - Chop target selects inhibit or phase lines.
// - Phase chopping raises the inactive phase line.
// - Oscillator pulse sets both chopper latches.
// - Comparator trip clears latch until next pulse.
// - Control register bit CTRL_EXTSYNC_BIT selects external sync.
// - Enable low forces all six drive outputs low.
// - Home output is high exactly in state 1.
// - Direction input is synchronised internally.
package spt_pkg;
   localparam int unsigned CLK_FREQ_HZ     = 25_000_000;
   localparam int unsigned RESET_TO_STEP_NS = 1000;
   localparam int unsigned RESET_TO_STEP_CYC =
      (RESET_TO_STEP_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
   localparam logic [2:0] HOME_STATE  = 3'h0;
   localparam logic [3:0] HOME_PHASES = 4'h5;
   localparam int unsigned OSC_DIV_DEFAULT = 1250;
   localparam int unsigned REG_CTRL    = 32'h0000_0000;
   localparam int unsigned REG_STATUS  = 32'h0000_0004;
   localparam int unsigned REG_OSCDIV  = 32'h0000_0008;
   localparam int unsigned CTRL_ENABLE_BIT  = 0;
   localparam int unsigned CTRL_CHOPPH_BIT  = 1;
   localparam int unsigned CTRL_EXTSYNC_BIT = 2;
   localparam logic [2:0] CTRL_RESET_VAL = 3'h0;
   localparam logic [15:0] OSCDIV_RESET_VAL = 16'h04E2;

   // Phase pattern A,B,C,D for translator state index 0..7 (state 1..8).
   function automatic logic [3:0] spt_phase_of(input logic [2:0] s);
      case (s)
         3'h0: spt_phase_of = 4'h5;
         3'h1: spt_phase_of = 4'h4;
         3'h2: spt_phase_of = 4'h6;
         3'h3: spt_phase_of = 4'h2;
         3'h4: spt_phase_of = 4'hA;
         3'h5: spt_phase_of = 4'h8;
         3'h6: spt_phase_of = 4'h9;
         default: spt_phase_of = 4'h1;
      endcase
   endfunction : spt_phase_of
endpackage : spt_pkg

// File: include/spt_drv_if.sv
// Interface between the translator and the output stage.
`timescale 1ns/1ps
interface spt_drv_if;
   logic [2:0] state;
   logic       half_mode;
   modport src (output state, output half_mode);
   modport dst (input state, input half_mode);
endinterface : spt_drv_if

// File: rtl/spt_sync2.sv
// Two flip-flop synchroniser for a bundle of levels.
`timescale 1ns/1ps
module spt_sync2 #(
   parameter int unsigned W = 1
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : spt_sync2

// File: rtl/spt_translator.sv
// Eight-state step translator advanced by rising edges of the step input.
`timescale 1ns/1ps
module spt_translator
   import spt_pkg::*;
(
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic step_rise,
   input  wire logic trans_reset,
   input  wire logic rotation_direction,
   input  wire logic half_full,
   spt_drv_if.src    drv
);
   logic [2:0] state_q, state_d;
   logic [2:0] inc;
   always_comb begin
      inc = half_full ? 3'h1 : 3'h2;
      // Full step from an odd state stays on odd states, from even on even.
      state_d = state_q;
      if (trans_reset) state_d = HOME_STATE;
      else if (step_rise) begin
         if (rotation_direction) state_d = state_q + inc;
         else state_d = state_q - inc;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) state_q <= HOME_STATE;
      else state_q <= state_d;
   end
   assign drv.state = state_q;
   assign drv.half_mode = half_full;
endmodule : spt_translator

// File: rtl/spt_top.sv
// Stepper translator and dual chopper with an AHB-Lite control port.
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module spt_top
   import spt_pkg::*;
#(
   parameter int unsigned OSC_DIV = OSC_DIV_DEFAULT
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        step_clock_n,
   input  wire logic        step_reset_n,
   input  wire logic        rotation_direction,
   input  wire logic        half_full,
   input  wire logic        current_sense_ab,
   input  wire logic        current_sense_cd,
   input  wire logic        sync_in,
   output logic             sync_out,
   output logic             sync_oe,
   output logic [3:0]       phase_outputs,
   output logic             inhibit_pair_ab_n,
   output logic             inhibit_pair_cd_n,
   output logic             home
);
   logic [6:0] pins_s;
   spt_sync2 #(.W(7)) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       ({step_clock_n, step_reset_n, rotation_direction, half_full,
                 current_sense_ab, current_sense_cd, sync_in}),
      .q       (pins_s)
   );
   logic clk_s, rst_n_s, dir_s, half_s, sens_ab_s, sens_cd_s, sync_s;
   assign {clk_s, rst_n_s, dir_s, half_s, sens_ab_s, sens_cd_s, sync_s} = pins_s;

   // Edge detection on synchronised levels only.
   // The step edge register rests at the idle high level of the step line, and it is held there
   // while the translator reset is active, so that leaving either reset cannot look like a step.
   logic clk_prev_q, sync_prev_q;
   logic step_rise;
   assign step_rise = clk_s & ~clk_prev_q & rst_n_s;

   // Register file.
   logic [2:0]  ctrl_q, ctrl_d;
   logic [15:0] oscdiv_q, oscdiv_d;
   logic        dph_valid_q, dph_valid_d;
   logic        dph_write_q, dph_write_d;
   logic [3:0]  dph_addr_q, dph_addr_d;
   logic [31:0] hrdata_d;

   spt_drv_if drv ();
   spt_translator u_trans (
      .hclk               (hclk),
      .hresetn            (hresetn),
      .step_rise          (step_rise),
      .trans_reset        (~rst_n_s),
      .rotation_direction (dir_s),
      .half_full          (half_s),
      .drv                (drv)
   );

   // Chopper oscillator: internal divider or external sync pulse.
   logic [15:0] osc_cnt_q, osc_cnt_d;
   logic        osc_pulse;
   logic        chop_latch_ab_q, chop_latch_ab_d;
   logic        chop_latch_cd_q, chop_latch_cd_d;
   logic        ext_sync;
   assign ext_sync = ctrl_q[CTRL_EXTSYNC_BIT];
   always_comb begin
      osc_cnt_d = osc_cnt_q + 16'h0001;
      if (osc_cnt_q >= oscdiv_q - 16'h0001) osc_cnt_d = 16'h0000;
      osc_pulse = ext_sync ? (sync_s & ~sync_prev_q) : (osc_cnt_q == 16'h0000);
      // Set wins over a trip in the same cycle, so a pulse always opens a period.
      chop_latch_ab_d = chop_latch_ab_q;
      chop_latch_cd_d = chop_latch_cd_q;
      if (sens_ab_s) chop_latch_ab_d = 1'b0;
      if (sens_cd_s) chop_latch_cd_d = 1'b0;
      if (osc_pulse) begin
         chop_latch_ab_d = 1'b1;
         chop_latch_cd_d = 1'b1;
      end
   end

   // Output stage.
   logic [3:0] ph;
   logic       wave_or_half;
   logic [3:0] phase_d;
   logic       inh_ab_d, inh_cd_d, home_d, sync_out_d;
   always_comb begin
      ph = spt_phase_of(drv.state);
      wave_or_half = drv.half_mode | drv.state[0]; // state index odd = even state
      inh_ab_d = 1'b1;
      inh_cd_d = 1'b1;
      if (wave_or_half) begin
         inh_ab_d = ph[3] | ph[2];
         inh_cd_d = ph[1] | ph[0];
      end
      phase_d = ph;
      if (ctrl_q[CTRL_CHOPPH_BIT]) begin
         if (!chop_latch_ab_q) phase_d[3:2] = 2'b11;
         if (!chop_latch_cd_q) phase_d[1:0] = 2'b11;
      end else begin
         inh_ab_d = inh_ab_d & chop_latch_ab_q;
         inh_cd_d = inh_cd_d & chop_latch_cd_q;
      end
      if (!ctrl_q[CTRL_ENABLE_BIT]) begin
         phase_d  = 4'h0;
         inh_ab_d = 1'b0;
         inh_cd_d = 1'b0;
      end
      home_d = (drv.state == HOME_STATE);
      sync_out_d = ~ext_sync & (osc_cnt_q == 16'h0000);
   end

   // Bus slave: zero-wait, always OKAY.
   always_comb begin
      // The registers fill only the lowest 16 bytes; a higher address must not alias one of them.
      dph_valid_d = hsel & hready & htrans[1] & (haddr[31:4] == 28'h0000000);
      dph_write_d = hwrite;
      dph_addr_d  = haddr[3:0];
      ctrl_d      = ctrl_q;
      oscdiv_d    = oscdiv_q;
      if (dph_valid_q && dph_write_q) begin
         if (dph_addr_q == REG_CTRL[3:0]) ctrl_d = hwdata[2:0];
         if (dph_addr_q == REG_OSCDIV[3:0]) oscdiv_d = (hwdata[15:0] == 16'h0000) ? 16'h0001 : hwdata[15:0];
      end
      hrdata_d = 32'h0000_0000;
      if (dph_valid_d && !hwrite) begin
         case (haddr[3:0])
            REG_CTRL[3:0]:   hrdata_d = {29'h0, ctrl_q};
            REG_STATUS[3:0]: hrdata_d = {22'h0, chop_latch_cd_q, chop_latch_ab_q, home, drv.state, phase_outputs};
            REG_OSCDIV[3:0]: hrdata_d = {16'h0, oscdiv_q};
            default:         hrdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_prev_q        <= 1'b1;
         sync_prev_q       <= 1'b0;
         ctrl_q            <= CTRL_RESET_VAL;
         oscdiv_q          <= OSCDIV_RESET_VAL;
         dph_valid_q       <= 1'b0;
         dph_write_q       <= 1'b0;
         dph_addr_q        <= 4'h0;
         osc_cnt_q         <= 16'h0000;
         chop_latch_ab_q   <= 1'b0;
         chop_latch_cd_q   <= 1'b0;
         phase_outputs     <= 4'h0;
         inhibit_pair_ab_n <= 1'b0;
         inhibit_pair_cd_n <= 1'b0;
         home              <= 1'b1;
         sync_out          <= 1'b0;
         sync_oe           <= 1'b0;
         hrdata            <= 32'h0000_0000;
         hreadyout         <= 1'b1;
         hresp             <= 1'b0;
      end else begin
         clk_prev_q        <= clk_s | ~rst_n_s;
         sync_prev_q       <= sync_s;
         ctrl_q            <= ctrl_d;
         oscdiv_q          <= oscdiv_d;
         dph_valid_q       <= dph_valid_d;
         dph_write_q       <= dph_write_d;
         dph_addr_q        <= dph_addr_d;
         osc_cnt_q         <= osc_cnt_d;
         chop_latch_ab_q   <= chop_latch_ab_d;
         chop_latch_cd_q   <= chop_latch_cd_d;
         phase_outputs     <= phase_d;
         inhibit_pair_ab_n <= inh_ab_d;
         inhibit_pair_cd_n <= inh_cd_d;
         home              <= home_d;
         sync_out          <= sync_out_d;
         sync_oe           <= ~ext_sync;
         hrdata            <= hrdata_d;
         hreadyout         <= 1'b1;
         hresp             <= 1'b0;
      end
   end
endmodule : spt_top

// File: verification/spt_top_props.sv
// Concurrent checks on the stepper translator and chopper top ports.
`timescale 1ns/1ps
module spt_top_props (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       step_reset_n,
   input wire logic       current_sense_ab,
   input wire logic       current_sense_cd,
   input wire logic       sync_out,
   input wire logic       sync_oe,
   input wire logic       inhibit_pair_ab_n,
   input wire logic       inhibit_pair_cd_n,
   input wire logic       home,
   input wire logic [3:0] phase_outputs
);
   default clocking dc @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   chk_home_pattern: assert property (phase_outputs == 4'h5 |-> home)
      else $error("home low while phases show the home pattern");
   chk_home_phases: assert property (home |-> phase_outputs inside {4'h0, 4'h5, 4'h7, 4'hD, 4'hF})
      else $error("home high with a foreign phase pattern");
   chk_idle_ab_inhibit: assert property (phase_outputs[3:2] == 2'b00 |-> !inhibit_pair_ab_n)
      else $error("idle pair ab not inhibited");
   chk_idle_cd_inhibit: assert property (phase_outputs[1:0] == 2'b00 |-> !inhibit_pair_cd_n)
      else $error("idle pair cd not inhibited");
   chk_sync_single: assert property (sync_out |=> !sync_out)
      else $error("oscillator pulse longer than one cycle");
   chk_reset_home: assert property ((!step_reset_n)[*6] |-> home)
      else $error("translator reset did not reach home");
   // The pulse only counts while driven; with external sync the own oscillator has no say.
   // The sense input reaches the latch three edges late, so it must be quiet two cycles before the pulse.
   chk_set_ab_drive: assert property (!current_sense_ab ##2 (sync_out && sync_oe)
      |-> ##2 (inhibit_pair_ab_n || phase_outputs[3:2] == 2'b00))
      else $error("pair ab not driven after oscillator pulse");
   chk_set_cd_drive: assert property (!current_sense_cd ##2 (sync_out && sync_oe)
      |-> ##2 (inhibit_pair_cd_n || phase_outputs[1:0] == 2'b00))
      else $error("pair cd not driven after oscillator pulse");
endmodule : spt_top_props
bind spt_top spt_top_props chk (.hclk, .hresetn, .step_reset_n, .current_sense_ab, .current_sense_cd,
   .sync_out, .sync_oe, .inhibit_pair_ab_n, .inhibit_pair_cd_n, .home, .phase_outputs);

// File: verification/spt_host_model.sv
// Host model issuing step pulses, direction, step size and translator reset.
`timescale 1ns/1ps
module spt_host_model
   import spt_pkg::*;
(
   input  wire logic hclk,
   output logic      step_clock_n,
   output logic      step_reset_n,
   output logic      rotation_direction,
   output logic      half_full
);
   initial begin
      step_clock_n = 1'b1;
      step_reset_n = 1'b1;
      rotation_direction = 1'b1;
      half_full = 1'b1;
   end
   // The step line rests high between pulses and is timed apart from the bus clock.
   task automatic step(input logic d, input logic h);
      @(posedge hclk);
      rotation_direction <= d;
      half_full <= h;
      #7 step_clock_n = 1'b0;
      #160 step_clock_n = 1'b1;
      #160;
   endtask : step
   task automatic park();
      @(posedge hclk);
      step_reset_n <= 1'b0;
      repeat (RESET_TO_STEP_CYC) @(posedge hclk);
      step_reset_n <= 1'b1;
      repeat (RESET_TO_STEP_CYC) @(posedge hclk);
   endtask : park
endmodule : spt_host_model

// File: verification/testbench.sv
// Self-checking testbench for the stepper translator and chopper.
`timescale 1ns/1ps
module testbench;
   import spt_pkg::*;
   typedef struct packed {logic [31:0] v; logic [31:0] m;} spt_note_s;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hwrite = 1'b0;
   logic        rd_q = 1'b0;
   logic [2:0]  pulse_q = 3'h0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [3:0]  phase_outputs;
   logic        hreadyout, hresp, step_clock_n, step_reset_n, rotation_direction, half_full, d, h;
   logic        sync_out, sync_oe, inhibit_pair_ab_n, inhibit_pair_cd_n, home;
   wire         current_sense_ab = pulse_q[0];
   wire         current_sense_cd = pulse_q[1];
   wire         sync_in = sync_oe ? sync_out : pulse_q[2];
   wire  [31:0] pins = {26'h0, phase_outputs, inhibit_pair_ab_n, inhibit_pair_cd_n};
   logic [2:0]  st = 3'h0;
   logic [3:0]  tab [8] = '{4'h5, 4'h4, 4'h6, 4'h2, 4'hA, 4'h8, 4'h9, 4'h1};
   int          err_count = 0;
   int          checks_done = 0;
   spt_note_s   q [$];
   always #20 hclk = ~hclk;
   spt_top uut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .step_clock_n, .step_reset_n, .rotation_direction,
      .half_full, .current_sense_ab, .current_sense_cd, .sync_in, .sync_out, .sync_oe, .phase_outputs,
      .inhibit_pair_ab_n, .inhibit_pair_cd_n, .home);
   spt_host_model host (.hclk, .step_clock_n, .step_reset_n, .rotation_direction, .half_full);
   task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask : cmp
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] v, input logic [31:0] m);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= v;
      rd_q <= !w;
      if (!w) q.push_back('{v, m});
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_q <= 1'b0;
   endtask : bus
   task automatic pulse(input int b);
      pulse_q[b] <= 1'b1;
      repeat (4) @(posedge hclk);
      pulse_q[b] <= 1'b0;
      repeat (20) @(posedge hclk);
   endtask : pulse
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up
   always @(posedge hclk) begin
      if (rd_q && hreadyout === 1'b1 && q.size() > 0) begin
         cmp("read data", q[0].v & q[0].m, hrdata & q[0].m);
         cmp("response", 32'h0, {31'h0, hresp});
         void'(q.pop_front());
      end
   end
   // About ten times the expected run, so a stalled bus or stuck step still ends.
   initial begin
      #400_000;
      err_count++;
      wrap_up();
   end
   initial begin
      void'($urandom(14));
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(0, REG_CTRL, 32'h0, 32'h7);
      bus(0, REG_OSCDIV, 32'h4E2, 32'hFFFF);
      bus(0, REG_STATUS, 32'h80, 32'hF0);
      bus(1, REG_OSCDIV, 32'h8, 32'h0);
      bus(1, REG_CTRL, 32'h1, 32'h0);
      // Reads and writes outside the map must not alias a live register.
      bus(0, 32'h10, 32'h0, 32'hFFFF_FFFF);
      bus(1, 32'h10, 32'h0, 32'h0);
      bus(0, REG_CTRL, 32'h1, 32'h7);
      for (int i = 0; i < 48; i++) begin
         if (i % 24 == 0) begin
            host.park();
            st = 3'h0;
         end
         d = 1'($urandom);
         h = 1'($urandom);
         host.step(d, h);
         st = st + (h ? (d ? 3'h1 : 3'h7) : (d ? 3'h2 : 3'h6));
         repeat (6) @(posedge hclk);
         bus(0, REG_STATUS, {24'h0, st == 3'h0, st, tab[st]}, 32'hFF);
      end
      host.park();
      bus(1, REG_CTRL, 32'h5, 32'h0);
      pulse(0);
      bus(0, REG_STATUS, 32'h200, 32'h300);
      pulse(2);
      bus(0, REG_STATUS, 32'h300, 32'h300);
      bus(1, REG_CTRL, 32'h7, 32'h0);
      pulse(1);
      cmp("drive pins", 32'h1F, pins);
      bus(1, REG_CTRL, 32'h5, 32'h0);
      repeat (6) @(posedge hclk);
      cmp("drive pins", 32'h16, pins);
      bus(1, REG_CTRL, 32'h0, 32'h0);
      repeat (6) @(posedge hclk);
      cmp("drive pins", 32'h0, pins);
      wrap_up();
   end
endmodule : testbench
